// file: design/tcm_core.v
// transfer controller core: descriptor fetch, data move and write-back in three modes
`timescale 1ns/10ps
`default_nettype none
`include "tcm_regs.vh"

module tcm_core (
  // clock and reset
  input wire CLOCK,
  input wire RST_B,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // hardware activation
  input wire ACT_REQ,
  input wire [7:0] ACT_SRC,
  output reg ACT_ACK,
  // system bus master
  output reg M_REQ,
  output reg M_WE,
  output reg [1:0] M_SIZE,
  output reg [31:0] M_ADDR,
  output reg [31:0] M_WDATA,
  input wire [31:0] M_RDATA,
  input wire M_ACK,
  // cpu side
  output reg CPU_IRQ,
  output reg BUSY
);

  // states
  localparam S_IDLE = 3'h0;
  localparam S_VEC = 3'h1;
  localparam S_RD = 3'h2;
  localparam S_DRD = 3'h3;
  localparam S_DWR = 3'h4;
  localparam S_INT = 3'h5;
  localparam S_WB = 3'h6;
  localparam S_END = 3'h7;

  reg [2:0] state;
  reg ctrl_en;
  reg [15:0] base_hi;
  reg sw_pend;
  reg [7:0] sw_vec;
  reg [7:0] src_num;
  reg [31:0] start_addr;
  reg [1:0] idx;
  reg [15:0] mode_w;
  reg [15:0] cnt;
  reg [31:0] aux;
  reg [31:0] sar;
  reg [31:0] dar;
  reg [31:0] data_buf;
  reg [16:0] blk_left;
  reg irq_due;
  reg [15:0] last_cnt;
  reg mem_we;
  reg [1:0] mem_wa;
  reg [31:0] mem_wd;
  wire [31:0] orig_addr;

  // mode word decode drives size and stepping of every data access; vector and descriptor accesses use fixed sizes
  wire [1:0] f_sm = mode_w[`TCM_MW_SM_HI:`TCM_MW_SM_LO];
  wire [1:0] f_dm = mode_w[`TCM_MW_DM_HI:`TCM_MW_DM_LO];
  wire [1:0] f_md = mode_w[`TCM_MW_MD_HI:`TCM_MW_MD_LO];
  wire [1:0] f_sz = mode_w[`TCM_MW_SZ_HI:`TCM_MW_SZ_LO];
  wire f_dts = mode_w[`TCM_MW_DTS_BIT];
  wire f_interrupt_select_bit = mode_w[`TCM_MW_INTERRUPT_SELECT_BIT_BIT];
  wire [31:0] step = (f_sz == `TCM_SZ_BYTE) ? 32'h00000001 :
                     (f_sz == `TCM_SZ_WORD) ? 32'h00000002 : 32'h00000004;
  wire [31:0] next_sar = (f_sm == `TCM_AU_INC) ? sar + step :
                         (f_sm == `TCM_AU_DEC) ? sar - step : sar;
  wire [31:0] next_dar = (f_dm == `TCM_AU_INC) ? dar + step :
                         (f_dm == `TCM_AU_DEC) ? dar - step : dar;

  // apb decode
  wire apb_setup = PSEL & ~PENABLE;
  wire apb_wr = PSEL & PENABLE & PWRITE & PREADY;
  wire addr_ok = (PADDR == `TCM_OFF_CTRL) || (PADDR == `TCM_OFF_BASE) || (PADDR == `TCM_OFF_SWACT) ||
                 (PADDR == `TCM_OFF_STATUS) || (PADDR == `TCM_OFF_LASTCNT);
  wire sw_set = apb_wr & (PADDR == `TCM_OFF_SWACT) & PWDATA[`TCM_SWACT_GO_BIT];
  wire can_start = (state == S_IDLE) & ctrl_en;
  wire take_hw = can_start & ACT_REQ;
  wire take_sw = can_start & ~ACT_REQ & sw_pend;

  // original source/destination as fetched, used to restore the block area
  tcm_desc_mem #(
    .DW(32),
    .DEPTH(4),
    .AW(2)
  ) u_desc (
    .clk(CLOCK),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_data(mem_wd),
    .rd_addr(f_dts ? `TCM_DW_SRC : `TCM_DW_DST),
    .rd_data(orig_addr)
  );

  // apb slave: zero wait state, answer prepared during the setup cycle
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else begin
      PREADY <= apb_setup;
      PSLVERR <= apb_setup & ~addr_ok;
      PRDATA <= 32'h00000000;
      if (apb_setup & ~PWRITE) begin
        case (PADDR)
          `TCM_OFF_CTRL: PRDATA <= {31'h00000000, ctrl_en};
          `TCM_OFF_BASE: PRDATA <= {base_hi, 16'h0000};
          `TCM_OFF_SWACT: PRDATA <= {23'h000000, sw_pend, sw_vec};
          `TCM_OFF_STATUS: PRDATA <= {24'h000000, src_num[4:0], state};
          `TCM_OFF_LASTCNT: PRDATA <= {16'h0000, last_cnt};
          default: PRDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // software-visible control; a new software request wins over its own clear on acceptance
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_en <= `TCM_CTRL_RESET;
      base_hi <= `TCM_BASE_RESET;
      sw_pend <= 1'b0;
      sw_vec <= 8'h00;
    end else begin
      if (apb_wr & (PADDR == `TCM_OFF_CTRL)) begin
        ctrl_en <= PWDATA[`TCM_CTRL_EN_BIT];
      end
      if (apb_wr & (PADDR == `TCM_OFF_BASE)) begin
        base_hi <= PWDATA[31:16];
      end
      if (sw_set) begin
        sw_pend <= 1'b1;
        sw_vec <= PWDATA[7:0];
      end else if (take_sw) begin
        sw_pend <= 1'b0;
      end
    end
  end

  // main sequencer: vector, descriptor read, data moves, internal step, write-back
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state <= S_IDLE;
      src_num <= 8'h00;
      start_addr <= 32'h00000000;
      idx <= 2'h0;
      mode_w <= 16'h0000;
      cnt <= 16'h0000;
      aux <= 32'h00000000;
      sar <= 32'h00000000;
      dar <= 32'h00000000;
      data_buf <= 32'h00000000;
      blk_left <= 17'h00000;
      irq_due <= 1'b0;
      last_cnt <= 16'h0000;
      mem_we <= 1'b0;
      mem_wa <= 2'h0;
      mem_wd <= 32'h00000000;
      M_REQ <= 1'b0;
      M_WE <= 1'b0;
      M_SIZE <= 2'h0;
      M_ADDR <= 32'h00000000;
      M_WDATA <= 32'h00000000;
      ACT_ACK <= 1'b0;
      CPU_IRQ <= 1'b0;
      BUSY <= 1'b0;
    end else begin
      ACT_ACK <= 1'b0;
      CPU_IRQ <= 1'b0;
      mem_we <= 1'b0;
      case (state)
        S_IDLE: begin
          BUSY <= 1'b0;
          if (take_hw | take_sw) begin
            src_num <= take_hw ? ACT_SRC : sw_vec;
            ACT_ACK <= take_hw;
            BUSY <= 1'b1;
            state <= S_VEC;
          end
        end
        // one 16-bit vector read per activation
        S_VEC: begin
          if (!M_REQ) begin
            M_REQ <= 1'b1;
            M_WE <= 1'b0;
            M_SIZE <= `TCM_SZ_WORD;
            M_ADDR <= `TCM_VEC_BASE + {23'h000000, src_num, 1'b0};
          end else if (M_ACK) begin
            M_REQ <= 1'b0;
            start_addr <= {base_hi, M_RDATA[15:0]};
            idx <= 2'h0;
            state <= S_RD;
          end
        end
        // four longword descriptor reads; word 1 holds unused bytes, initial address or length
        S_RD: begin
          if (!M_REQ) begin
            M_REQ <= 1'b1;
            M_WE <= 1'b0;
            M_SIZE <= `TCM_SZ_LONG;
            M_ADDR <= start_addr + {28'h0000000, idx, 2'h0};
          end else if (M_ACK) begin
            M_REQ <= 1'b0;
            mem_we <= 1'b1;
            mem_wa <= idx;
            mem_wd <= M_RDATA;
            case (idx)
              `TCM_DW_MODECNT: begin
                mode_w <= M_RDATA[31:16];
                cnt <= M_RDATA[15:0];
              end
              `TCM_DW_AUX: aux <= M_RDATA;
              `TCM_DW_SRC: sar <= M_RDATA;
              default: dar <= M_RDATA;
            endcase
            idx <= idx + 2'h1;
            if (idx == `TCM_DW_DST) begin
              // block length 0 stands for 65536 units
              blk_left <= (aux[15:0] == 16'h0000) ? 17'h10000 : {1'b0, aux[15:0]};
              state <= S_DRD;
            end
          end
        end
        // data read of one unit
        S_DRD: begin
          if (!M_REQ) begin
            M_REQ <= 1'b1;
            M_WE <= 1'b0;
            M_SIZE <= f_sz;
            M_ADDR <= sar;
          end else if (M_ACK) begin
            M_REQ <= 1'b0;
            data_buf <= M_RDATA;
            state <= S_DWR;
          end
        end
        // data write of one unit; block mode loops for the whole block
        S_DWR: begin
          if (!M_REQ) begin
            M_REQ <= 1'b1;
            M_WE <= 1'b1;
            M_SIZE <= f_sz;
            M_ADDR <= dar;
            M_WDATA <= data_buf;
          end else if (M_ACK) begin
            M_REQ <= 1'b0;
            M_WE <= 1'b0;
            sar <= next_sar;
            dar <= next_dar;
            blk_left <= blk_left - 17'h00001;
            if ((f_md == `TCM_MD_BLOCK) && (blk_left != 17'h00001)) begin
              state <= S_DRD;
            end else begin
              state <= S_INT;
            end
          end
        end
        // internal step: compute the values to write back
        S_INT: begin
          idx <= `TCM_DW_MODECNT;
          state <= S_WB;
          case (f_md)
            `TCM_MD_REPEAT: begin
              // low byte 0 stands for 256 transfers
              if (cnt[7:0] == 8'h01) begin
                cnt[7:0] <= cnt[15:8];
                if (f_dts) begin
                  sar <= aux;
                end else begin
                  dar <= aux;
                end
              end else begin
                cnt[7:0] <= cnt[7:0] - 8'h01;
              end
              irq_due <= f_interrupt_select_bit;
            end
            `TCM_MD_BLOCK: begin
              cnt <= cnt - 16'h0001;
              if (f_dts) begin
                sar <= orig_addr;
              end else begin
                dar <= orig_addr;
              end
              irq_due <= f_interrupt_select_bit | (cnt == 16'h0001);
            end
            default: begin
              cnt <= cnt - 16'h0001;
              irq_due <= f_interrupt_select_bit | (cnt == 16'h0001);
            end
          endcase
        end
        // three write-backs: mode/count, source, destination; word 1 never written
        S_WB: begin
          if (!M_REQ) begin
            M_REQ <= 1'b1;
            M_WE <= 1'b1;
            M_SIZE <= `TCM_SZ_LONG;
            M_ADDR <= start_addr + {28'h0000000, idx, 2'h0};
            M_WDATA <= (idx == `TCM_DW_MODECNT) ? {mode_w, cnt} :
                       (idx == `TCM_DW_SRC) ? sar : dar;
          end else if (M_ACK) begin
            M_REQ <= 1'b0;
            M_WE <= 1'b0;
            if (idx == `TCM_DW_MODECNT) begin
              idx <= `TCM_DW_SRC;
            end else if (idx == `TCM_DW_SRC) begin
              idx <= `TCM_DW_DST;
            end else begin
              state <= S_END;
            end
          end
        end
        S_END: begin
          CPU_IRQ <= irq_due;
          last_cnt <= cnt;
          BUSY <= 1'b0;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule // tcm_core

`default_nettype wire

// file: design/tcm_desc_mem.v
// small descriptor store with registered read data
`timescale 1ns/10ps
`default_nettype none

module tcm_desc_mem #(
  parameter DW = 32,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // clock
  input wire clk,
  // write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  // read port
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);

  reg [DW-1:0] mem [0:DEPTH-1];

  // storage needs no reset: every word is written before it is read
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // tcm_desc_mem

`default_nettype wire

// file: design/tcm_regs.vh
// constants for the transfer controller: register offsets, descriptor layout and field positions
`ifndef TCM_REGS_VH
`define TCM_REGS_VH

// apb register byte offsets
`define TCM_OFF_CTRL 12'h000
`define TCM_OFF_BASE 12'h004
`define TCM_OFF_SWACT 12'h008
`define TCM_OFF_STATUS 12'h00C
`define TCM_OFF_LASTCNT 12'h010

// control register fields and reset values
`define TCM_CTRL_EN_BIT 0
`define TCM_CTRL_RESET 1'h0
`define TCM_BASE_RESET 16'h0000
`define TCM_SWACT_GO_BIT 8

// vector table base and entry stride (bytes)
`define TCM_VEC_BASE 32'h00000400
`define TCM_VEC_STRIDE 32'h00000002

// descriptor word indexes (32-bit words from the start address)
`define TCM_DW_MODECNT 2'h0
`define TCM_DW_AUX 2'h1
`define TCM_DW_SRC 2'h2
`define TCM_DW_DST 2'h3
`define TCM_DESC_WORDS 3'h4

// mode word fields
`define TCM_MW_SM_HI 15
`define TCM_MW_SM_LO 14
`define TCM_MW_DM_HI 13
`define TCM_MW_DM_LO 12
`define TCM_MW_MD_HI 11
`define TCM_MW_MD_LO 10
`define TCM_MW_SZ_HI 9
`define TCM_MW_SZ_LO 8
`define TCM_MW_DTS_BIT 7
`define TCM_MW_INTERRUPT_SELECT_BIT_BIT 5

// operating modes
`define TCM_MD_NORMAL 2'h0
`define TCM_MD_REPEAT 2'h1
`define TCM_MD_BLOCK 2'h2

// address update codes
`define TCM_AU_INC 2'h2
`define TCM_AU_DEC 2'h3

// data unit sizes
`define TCM_SZ_BYTE 2'h0
`define TCM_SZ_WORD 2'h1
`define TCM_SZ_LONG 2'h2

`endif

// file: test/tcm_core_properties.sv
// port-level assertions for the transfer controller core
`timescale 1ns/10ps
`default_nettype none
`include "tcm_regs.vh"

module tcm_core_properties (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // apb and activation
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [7:0] ACT_SRC,
  input wire logic ACT_ACK,
  // system bus and cpu side
  input wire logic M_REQ,
  input wire logic M_WE,
  input wire logic [1:0] M_SIZE,
  input wire logic [31:0] M_ADDR,
  input wire logic [31:0] M_WDATA,
  input wire logic M_ACK,
  input wire logic CPU_IRQ,
  input wire logic BUSY
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  property p_ready; PSEL && !PENABLE |=> PREADY; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_err; PSLVERR |-> PREADY; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_ack; ACT_ACK |-> BUSY ##1 !ACT_ACK; endproperty
  a_ack: assert property (p_ack) else $error("bad activation ack");
  property p_vec;
    ACT_ACK |=> M_REQ && !M_WE && M_SIZE == `TCM_SZ_WORD && M_ADDR == `TCM_VEC_BASE + {23'h0, $past(ACT_SRC, 2), 1'b0};
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector read");
  property p_desc;
    M_REQ && M_ACK && M_SIZE == `TCM_SZ_WORD && M_ADDR[31:9] == 23'h2 |=> !M_REQ ##[1:4] (M_REQ && !M_WE && M_SIZE == `TCM_SZ_LONG);
  endproperty
  a_desc: assert property (p_desc) else $error("descriptor fetch not long");
  property p_hold;
    M_REQ && !M_ACK |=> M_REQ && $stable(M_ADDR) && $stable(M_WE) && $stable(M_SIZE) && $stable(M_WDATA);
  endproperty
  a_hold: assert property (p_hold) else $error("bus request changed");
  property p_gap; M_REQ && M_ACK |=> !M_REQ; endproperty
  a_gap: assert property (p_gap) else $error("no gap between accesses");
  property p_idle; !BUSY |-> !M_REQ; endproperty
  a_idle: assert property (p_idle) else $error("bus used while idle");
  property p_irq; CPU_IRQ |-> !M_REQ ##1 !CPU_IRQ; endproperty
  a_irq: assert property (p_irq) else $error("bad cpu interrupt pulse");
endmodule // tcm_core_properties

bind tcm_core tcm_core_properties u_props (.CLOCK, .RST_B, .PSEL, .PENABLE, .PREADY, .PSLVERR, .ACT_SRC, .ACT_ACK,
  .M_REQ, .M_WE, .M_SIZE, .M_ADDR, .M_WDATA, .M_ACK, .CPU_IRQ, .BUSY);

`default_nettype wire

// file: test/tcm_mem_model.sv
// behavioural system memory that answers the controller's bus requests
`timescale 1ns/10ps
`default_nettype none

module tcm_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bus from the controller
  input wire logic m_req,
  input wire logic m_we,
  input wire logic [1:0] m_size,
  input wire logic [31:0] m_addr,
  input wire logic [31:0] m_wdata,
  output logic [31:0] m_rdata,
  output logic m_ack,
  // answer delay in cycles
  input wire logic [1:0] dly
);
  logic [7:0] mem [0:8191];
  logic [1:0] cnt;
  logic [12:0] a;
  int n_rd = 0;
  int n_wr = 0;

  // bit 16 kept so the descriptor area does not alias the vector table
  assign a = {m_addr[16], m_addr[11:0]};

  // one-cycle ack after the chosen delay; read data is junk outside the ack cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      m_ack <= 1'b0;
      cnt <= 2'h0;
      m_rdata <= 32'h0;
    end else if (m_req && !m_ack && cnt == dly) begin
      m_ack <= 1'b1;
      cnt <= 2'h0;
      m_rdata <= {mem[a + 13'h3], mem[a + 13'h2], mem[a + 13'h1], mem[a]};
    end else begin
      m_ack <= 1'b0;
      m_rdata <= ~m_rdata;
      if (m_req && !m_ack) cnt <= cnt + 2'h1;
    end
  end

  // a write lands at the edge where the ack is seen, little-endian lanes
  always @(posedge clk) begin
    if (m_req && m_ack && m_we) begin
      n_wr++;
      for (int i = 0; i < 4; i++) if (i < (1 << m_size)) mem[a + i] <= m_wdata[8*i +: 8];
    end else if (m_req && m_ack) begin
      n_rd++;
    end
  end
endmodule // tcm_mem_model

`default_nettype wire

// file: test/transfer_controller_modes_test.sv
// self-checking bench: apb setup, then normal, repeat and block activations
`timescale 1ns/10ps
`default_nettype none
`include "tcm_regs.vh"

module transfer_controller_modes_test;
  logic CLOCK, RST_B, PSEL, PENABLE, PWRITE, ACT_REQ, PREADY, PSLVERR, ACT_ACK, M_REQ, M_WE, M_ACK, CPU_IRQ, BUSY;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, M_ADDR, M_WDATA, M_RDATA, rd;
  logic [7:0] ACT_SRC;
  logic [1:0] M_SIZE, dly;
  logic err;
  int num_errors = 0;
  int tests_run = 0;
  int irqs = 0;
  int r0, w0, i1;

  tcm_core dut (.CLOCK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .ACT_REQ,
    .ACT_SRC, .ACT_ACK, .M_REQ, .M_WE, .M_SIZE, .M_ADDR, .M_WDATA, .M_RDATA, .M_ACK, .CPU_IRQ, .BUSY);
  tcm_mem_model mdl (.clk(CLOCK), .rst_b(RST_B), .m_req(M_REQ), .m_we(M_WE), .m_size(M_SIZE), .m_addr(M_ADDR),
    .m_wdata(M_WDATA), .m_rdata(M_RDATA), .m_ack(M_ACK), .dly(dly));

  // 20 mhz clock
  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end

  // count cpu interrupt pulses
  always @(posedge CLOCK) if (CPU_IRQ === 1'b1) irqs++;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // bounded wait on a design output (0 ready, 1 activation ack, 2 busy); a hang counts as a mismatch
  // the output is read by name each pass, so no by-reference argument is needed
  task automatic wait_lvl(input int sel, input logic lvl);
    int i;
    for (i = 0; i < 3000 && ((sel == 0) ? PREADY : (sel == 1) ? ACT_ACK : BUSY) !== lvl; i++) @(posedge CLOCK);
    if (i == 3000) begin
      num_errors++;
      end_of_test();
    end
  endtask

  // one apb transfer; the leading edge keeps release and next setup apart
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= ad;
    PWDATA <= wd;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    @(posedge CLOCK);
    wait_lvl(0, 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // hardware activation, then check the interrupt pulses it raised
  task automatic act(input logic [7:0] src, input int nirq);
    int i0;
    r0 = mdl.n_rd;
    w0 = mdl.n_wr;
    i0 = irqs;
    @(posedge CLOCK);
    ACT_REQ <= 1'b1;
    ACT_SRC <= src;
    wait_lvl(1, 1'b1);
    ACT_REQ <= 1'b0;
    wait_lvl(2, 1'b0);
    repeat (3) @(posedge CLOCK);
    chk(irqs - i0, nirq);
  endtask

  task automatic put(input logic [31:0] a, input logic [31:0] v);
    for (int k = 0; k < 4; k++) mdl.mem[{a[16], a[11:0]} + k] = v[8*k +: 8];
  endtask

  function automatic logic [31:0] get(input logic [31:0] a);
    logic [12:0] i;
    i = {a[16], a[11:0]};
    return {mdl.mem[i + 13'h3], mdl.mem[i + 13'h2], mdl.mem[i + 13'h1], mdl.mem[i]};
  endfunction

  initial begin
    RST_B = 1'b0;
    {PSEL, PENABLE, PWRITE, ACT_REQ} = 4'h0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    ACT_SRC = 8'h00;
    dly = 2'h0;
    // vectors: source 3 -> 0100, 4 -> 0140, 5 -> 0180
    put(32'h404, 32'h0100_0000);
    put(32'h408, 32'h0180_0140);
    // normal: long, both sides step up, count 2; word1 is junk that must not matter
    put(32'h10100, 32'hA200_0002);
    put(32'h10104, 32'hDEAD_BEEF);
    put(32'h10108, 32'hC00);
    put(32'h1010C, 32'hD00);
    put(32'hC00, 32'h1111_1111);
    put(32'hC04, 32'h2222_2222);
    put(32'hC08, 32'h4444_4444);
    // repeat: source is the repeat side, reload 2, low byte at 1, interrupt select 0
    put(32'h10140, 32'hA680_0201);
    put(32'h10144, 32'h800);
    put(32'h10148, 32'h810);
    put(32'h1014C, 32'h900);
    put(32'h810, 32'h3333_3333);
    // block: destination is the block area, one block of three longwords
    put(32'h10180, 32'hAA00_0001);
    put(32'h10184, 32'h0000_0003);
    put(32'h10188, 32'hA00);
    put(32'h1018C, 32'hB00);
    for (int k = 0; k < 3; k++) put(32'hA00 + 4 * k, 32'hC0DE_0000 + k);
    repeat (10) @(posedge CLOCK);
    RST_B <= 1'b1;
    apb(1'b0, `TCM_OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `TCM_OFF_BASE, 32'h0001_0000);
    apb(1'b0, `TCM_OFF_BASE, 32'h0);
    chk(rd, 32'h0001_0000);
    apb(1'b0, 12'h0FC, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, `TCM_OFF_CTRL, 32'h1);
    // normal mode, prompt partner
    act(8'h03, 0);
    chk(get(32'h10100), 32'hA200_0001);
    chk(get(32'h10108), 32'hC04);
    chk(get(32'h1010C), 32'hD04);
    chk(get(32'hD00), 32'h1111_1111);
    chk(mdl.n_rd - r0, 6);
    chk(mdl.n_wr - w0, 4);
    act(8'h03, 1);
    chk(get(32'h10100), 32'hA200_0000);
    chk(get(32'hD04), 32'h2222_2222);
    // repeat mode, slow partner
    dly <= 2'h2;
    act(8'h04, 0);
    chk(get(32'h900), 32'h3333_3333);
    chk(get(32'h10140), 32'hA680_0202);
    chk(get(32'h10144), 32'h800);
    chk(get(32'h10148), 32'h800);
    chk(get(32'h1014C), 32'h904);
    // block mode, one-cycle partner delay
    dly <= 2'h1;
    act(8'h05, 1);
    for (int k = 0; k < 3; k++) chk(get(32'hB00 + 4 * k), 32'hC0DE_0000 + k);
    chk(get(32'h10180), 32'hAA00_0000);
    chk(get(32'h10184), 32'h3);
    chk(get(32'h10188), 32'hA0C);
    chk(get(32'h1018C), 32'hB00);
    chk(mdl.n_rd - r0, 8);
    chk(mdl.n_wr - w0, 6);
    // software activation of source 3 at count 0, which stands for 65536 transfers
    i1 = irqs;
    apb(1'b1, `TCM_OFF_SWACT, 32'h0000_0103);
    wait_lvl(2, 1'b1);
    wait_lvl(2, 1'b0);
    apb(1'b0, `TCM_OFF_LASTCNT, 32'h0);
    chk(rd, 32'h0000_FFFF);
    chk(get(32'h10100), 32'hA200_FFFF);
    chk(get(32'hD08), 32'h4444_4444);
    chk(irqs - i1, 0);
    end_of_test();
  end
endmodule // transfer_controller_modes_test

`default_nettype wire
